// *** logic/irq_unit_pkg.sv ***
// Notes on behaviour
// [R1] gate low masks all but power-fail
// [R2] gate high defers to each source enable
// [R3] timer 2 enable covers overflow and capture
// [R4] serial enable covers transmit and receive flags
// [R5] standard enables for t1,e1,t0,e0 at bits 3..0
// [R6] power-fail priority bit six, one is high
// [R7] standard priorities sit at bits 5..0
// [R8] extended flags set on line detection
// [R9] software clears extended flags, not vectoring
// [R10] software set of extended flag raises interrupt
// [R11] power-fail enable gates low-battery interrupt
// [R12] power-fail flag set on event, software clears
// [R13] software set of power-fail flag interrupts
// [R14] extended enables at bits 7..0
// [R15] extended priorities at bits 7..0, one is high
// [R16] six registers decoded at fixed addresses
// [R17] timer 2 bits stored even when absent
// [R18] fixed vectors in steps of eight bytes
// [R19] only higher level preempts active service
// [R20] equal level resolved by arrival order
// [R21] timer 0 and 1 flags and edge pin flags cleared on vectoring
// [R22] unused standard bits read zero
package irq_unit_pkg;
    localparam logic [7:0] ADDR_EXT_FLAGS = 8'h91;
    localparam logic [7:0] ADDR_PF_CTRL = 8'h93;
    localparam logic [7:0] ADDR_STD_EN = 8'ha8;
    localparam logic [7:0] ADDR_STD_PRIO = 8'ha9;
    localparam logic [7:0] ADDR_EXT_EN = 8'he8;
    localparam logic [7:0] ADDR_EXT_PRIO = 8'he9;
    localparam logic [7:0] STD_EN_MASK = 8'hbf;
    localparam logic [7:0] STD_PRIO_MASK = 8'h7f;
    localparam logic [7:0] PF_CTRL_MASK = 8'h30;
    localparam int GATE_BIT = 7;
    localparam int PF_EN_BIT = 5;
    localparam int PF_FLAG_BIT = 4;
    localparam int PF_PRIO_BIT = 6;
    localparam int NSRC = 15;
    localparam int SRC_PF = 6;
    localparam int SRC_EXT0 = 7;
    localparam logic [7:0] VEC_BASE = 8'h03;
    localparam logic [7:0] VEC_STEP = 8'h08;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int ARR_W = 4;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;
    typedef struct packed {
        logic t0_ovf;
        logic t1_ovf;
        logic t2_ovf;
        logic t2_cap;
        logic tx_done;
        logic rx_done;
        logic ext0_pin_n;
        logic ext1_pin_n;
        logic ext0_edge;
        logic ext1_edge;
        logic lowbatt_detect;
        logic [7:0] ext_lines;
    } irq_src_s;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b100
    } svc_e;
endpackage : irq_unit_pkg

// *** logic/irq_arbiter.sv ***
`timescale 1ns/1ps
// picks the oldest pending request of the winning level
module irq_arbiter #(
    parameter int N = 15,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // requests and their levels
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] hi,
    input wire logic only_high,
    input wire logic block_all,
    // choice
    output logic valid,
    output logic [AW-1:0] idx
);
    typedef struct packed {
        logic [N-1:0][AW-1:0] age;
    } arb_state_s;
    arb_state_s state;
    arb_state_s next_state;
    logic found;
    logic found_hi;
    logic [AW-1:0] best_age;
    logic [AW-1:0] pick;
    // ages saturate; older request wins, lower index breaks ties
    always_comb begin
        next_state = state;
        found = 1'b0;
        found_hi = 1'b0;
        best_age = '0;
        pick = '0;
        for (int i = 0; i < N; i++) begin
            if (!req[i]) begin
                next_state.age[i] = '0;
            end else if (state.age[i] != '1) begin
                next_state.age[i] = state.age[i] + 1'b1;
            end
        end
        for (int i = 0; i < N; i++) begin
            if (req[i] && (hi[i] || !only_high)) begin
                if (!found || (hi[i] && !found_hi) ||
                    (hi[i] == found_hi && state.age[i] > best_age)) begin // R20
                    found = 1'b1;
                    found_hi = hi[i];
                    best_age = state.age[i];
                    pick = AW'(i);
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign valid = found && !block_all;
    assign idx = pick;
endmodule : irq_arbiter

// *** logic/irq_unit.sv ***
`timescale 1ns/1ps
module irq_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // special-function register port
    input wire irq_unit_pkg::sfr_req_s sfr,
    output logic [7:0] sfr_rdata,
    // interrupt sources
    input wire irq_unit_pkg::irq_src_s src,
    input wire logic tmr2_present,
    // core side
    output logic irq_req,
    output logic [7:0] irq_vector,
    input wire logic irq_ack,
    input wire logic irq_return,
    output logic t0_clear,
    output logic t1_clear
);
    import irq_unit_pkg::*;
    typedef struct packed {
        logic [7:0] std_en;
        logic [7:0] std_prio;
        logic [7:0] ext_flags;
        logic [7:0] pf_ctrl;
        logic [7:0] ext_en;
        logic [7:0] ext_prio;
        logic ie0;
        logic ie1;
        logic pin0_q;
        logic pin1_q;
        svc_e svc;
        svc_e svc_prev;
        logic [7:0] rdata;
        logic [7:0] vector;
        logic t0_clr;
        logic t1_clr;
    } unit_state_s;
    unit_state_s state;
    unit_state_s next_state;
    logic [NSRC-1:0] pend;
    logic [NSRC-1:0] enab;
    logic [NSRC-1:0] level;
    logic gate;
    logic arb_valid;
    logic [ARR_W-1:0] arb_idx;
    logic [ARR_W-1:0] taken;

    // vector of a source index: base plus eight bytes per step
    function automatic logic [7:0] vec_of(input logic [ARR_W-1:0] i);
        logic [7:0] n;
        n = (i >= ARR_W'(SRC_EXT0)) ? 8'(i) + 8'h01 : 8'(i);
        return VEC_BASE + 8'(n * VEC_STEP);
    endfunction : vec_of

    // pin flag: level mode follows the pin, edge mode holds a falling step until vectoring
    function automatic logic pin_flag(input logic edge_mode, input logic prev_n, input logic pin_n,
        input logic held);
        return edge_mode ? (held | (prev_n & ~pin_n)) : ~pin_n;
    endfunction : pin_flag

    // pending and enabled vectors in priority-table order
    always_comb begin
        gate = state.std_en[GATE_BIT];
        pend = {state.ext_flags, state.pf_ctrl[PF_FLAG_BIT],
                tmr2_present & (src.t2_ovf | src.t2_cap), // R17
                src.tx_done | src.rx_done, src.t1_ovf, state.ie1, src.t0_ovf, state.ie0};
        enab = {state.ext_en & {8{gate}}, // R14
                state.pf_ctrl[PF_EN_BIT], // R1 R11
                state.std_en[5:0] & {6{gate}}}; // R2 R3 R4 R5
        level = {state.ext_prio, state.std_prio[PF_PRIO_BIT], state.std_prio[5:0]}; // R6 R7 R15
    end

    irq_arbiter #(
        .N(NSRC),
        .AW(ARR_W)
    ) u_arb (
        .clk(clk),
        .rst(rst),
        .req(pend & enab),
        .hi(level),
        .only_high(state.svc == ST_LOW), // R19
        .block_all(state.svc == ST_HIGH),
        .valid(arb_valid),
        .idx(arb_idx)
    );

    // register writes, flag sets and service nesting
    always_comb begin
        next_state = state;
        next_state.t0_clr = 1'b0;
        next_state.t1_clr = 1'b0;
        taken = arb_idx;
        // pin flags: a level flag follows its pin, so a pin released inside the service
        // routine does not bring the same request back after return
        next_state.ie0 = pin_flag(src.ext0_edge, state.pin0_q, src.ext0_pin_n, state.ie0);
        next_state.ie1 = pin_flag(src.ext1_edge, state.pin1_q, src.ext1_pin_n, state.ie1);
        next_state.pin0_q = src.ext0_pin_n; // reset low, so no false step follows reset
        next_state.pin1_q = src.ext1_pin_n;
        if (sfr.wr) begin
            case (sfr.addr) // R16
                ADDR_STD_EN: next_state.std_en = sfr.wdata & STD_EN_MASK; // R22
                ADDR_STD_PRIO: next_state.std_prio = sfr.wdata & STD_PRIO_MASK; // R22
                ADDR_EXT_FLAGS: next_state.ext_flags = sfr.wdata; // R10
                ADDR_PF_CTRL: next_state.pf_ctrl = sfr.wdata & PF_CTRL_MASK; // R13 R22
                ADDR_EXT_EN: next_state.ext_en = sfr.wdata;
                ADDR_EXT_PRIO: next_state.ext_prio = sfr.wdata;
                default: next_state = next_state;
            endcase
        end
        // hardware sets win over a software clear in the same cycle
        next_state.ext_flags = next_state.ext_flags | src.ext_lines; // R8 R9
        if (src.lowbatt_detect) begin
            next_state.pf_ctrl[PF_FLAG_BIT] = 1'b1; // R12
        end
        if (irq_ack && arb_valid) begin
            next_state.vector = vec_of(taken); // R18
            next_state.svc_prev = state.svc;
            next_state.svc = level[taken] ? ST_HIGH : ST_LOW;
            case (taken) // R21
                // a falling step in the vectoring cycle survives the clear
                ARR_W'(0): next_state.ie0 = pin_flag(src.ext0_edge, state.pin0_q, src.ext0_pin_n, 1'b0);
                ARR_W'(1): next_state.t0_clr = 1'b1;
                ARR_W'(2): next_state.ie1 = pin_flag(src.ext1_edge, state.pin1_q, src.ext1_pin_n, 1'b0);
                ARR_W'(3): next_state.t1_clr = 1'b1;
                default: next_state.t0_clr = 1'b0;
            endcase
        end else if (irq_return) begin
            // one level of nesting remembered; returning from low goes idle
            next_state.svc = (state.svc == ST_HIGH) ? state.svc_prev : ST_IDLE;
            next_state.svc_prev = ST_IDLE;
        end
        case (sfr.addr)
            ADDR_STD_EN: next_state.rdata = state.std_en;
            ADDR_STD_PRIO: next_state.rdata = state.std_prio;
            ADDR_EXT_FLAGS: next_state.rdata = state.ext_flags;
            ADDR_PF_CTRL: next_state.rdata = state.pf_ctrl;
            ADDR_EXT_EN: next_state.rdata = state.ext_en;
            ADDR_EXT_PRIO: next_state.rdata = state.ext_prio;
            default: next_state.rdata = REG_RESET;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '0;
            state.svc <= ST_IDLE;
            state.svc_prev <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign sfr_rdata = state.rdata;
    assign irq_req = arb_valid; // R1 R2
    assign irq_vector = state.vector;
    assign t0_clear = state.t0_clr;
    assign t1_clear = state.t1_clr;

    // checks
    gate_mask_a: assert property (@(posedge clk) disable iff (rst) // R1
        (!state.std_en[GATE_BIT] && irq_req) |-> (pend[SRC_PF] && state.pf_ctrl[PF_EN_BIT]))
        else $error("masked source passed the gate");
    pf_flag_a: assert property (@(posedge clk) disable iff (rst) // R12
        src.lowbatt_detect |=> state.pf_ctrl[PF_FLAG_BIT])
        else $error("power-fail flag not set");
    ext_flag_a: assert property (@(posedge clk) disable iff (rst) // R8
        src.ext_lines[0] |=> state.ext_flags[0])
        else $error("extended flag not set");
    sw_set_a: assert property (@(posedge clk) disable iff (rst) // R10
        (sfr.wr && sfr.addr == ADDR_EXT_FLAGS && sfr.wdata[7]) |=> state.ext_flags[7])
        else $error("software set lost");
    high_block_a: assert property (@(posedge clk) disable iff (rst) // R19
        (state.svc == ST_HIGH) |-> !irq_req)
        else $error("preempted a high service");
    unused_zero_a: assert property (@(posedge clk) disable iff (rst) // R22
        (state.std_en[6] == 1'b0) && (state.std_prio[7] == 1'b0) && ((state.pf_ctrl & ~PF_CTRL_MASK) == 8'h00))
        else $error("unused bit stored");
    vec_t0_a: assert property (@(posedge clk) disable iff (rst) // R18 R21
        (irq_ack && irq_req && arb_idx == ARR_W'(1)) |=> (irq_vector == 8'h0b && t0_clear))
        else $error("timer 0 vector wrong");
    t2_absent_a: assert property (@(posedge clk) disable iff (rst) // R17
        !tmr2_present |-> !pend[5])
        else $error("absent timer 2 requested");
    // an edge flag must drop on vectoring unless a new falling step arrives with it
    edge_clear_a: assert property (@(posedge clk) disable iff (rst) // R21
        (src.ext0_edge && irq_ack && arb_valid && arb_idx == ARR_W'(0) && !(state.pin0_q && !src.ext0_pin_n))
        |=> !state.ie0)
        else $error("edge flag kept after vectoring");
    ack_c: cover property (@(posedge clk) disable iff (rst) irq_ack && irq_req);
    edge_c: cover property (@(posedge clk) disable iff (rst) src.ext0_edge && irq_ack && irq_req);
    nest_c: cover property (@(posedge clk) disable iff (rst) state.svc == ST_LOW ##1 state.svc == ST_HIGH);
    pf_c: cover property (@(posedge clk) disable iff (rst) !gate && irq_req);
endmodule : irq_unit

// *** dv/irq_cpu_model.sv ***
`timescale 1ns/1ps
// core side: takes a request after ack_wait cycles and ends service on command
module irq_cpu_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control from the bench
    input wire logic ack_en,
    input wire logic [3:0] ack_wait,
    input wire logic ret_cmd,
    // interrupt handshake
    input wire logic irq_req,
    output logic irq_ack,
    output logic irq_return
);
    logic [3:0] cnt;
    // ack is one cycle wide and never back to back, so a request is taken once
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 4'h0;
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
        end else begin
            irq_return <= ret_cmd & ~irq_return;
            irq_ack <= 1'b0;
            if (irq_req && ack_en && !irq_ack) begin
                if (cnt == ack_wait) begin
                    irq_ack <= 1'b1;
                    cnt <= 4'h0;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end else begin
                cnt <= 4'h0;
            end
        end
    end
endmodule : irq_cpu_model

// *** dv/mcu_interrupt_enable_priority_unit_tb_top.sv ***
`timescale 1ns/1ps
module mcu_interrupt_enable_priority_unit_tb_top;
    import irq_unit_pkg::*;
    localparam irq_src_s IDLE = 19'h01800;
    logic clk, rst, tmr2_present, ack_en, ret_cmd, irq_req, irq_ack, irq_return, t0_clear, t1_clear;
    logic [3:0] ack_wait;
    logic [7:0] sfr_rdata, irq_vector, d;
    sfr_req_s sfr;
    irq_src_s src;
    int num_errors, num_checks;
    // address, written value, value read back
    logic [23:0] rows [7] = '{24'ha8ffbf, 24'ha9ff7f, 24'h93ff30, 24'h91a5a5, 24'he8ffff, 24'he9ffff, 24'h90ff00};
    int pos [6] = '{12, 18, 11, 17, 13, 15};
    irq_unit i_irq_unit (.clk(clk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata), .src(src),
        .tmr2_present(tmr2_present), .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
        .irq_return(irq_return), .t0_clear(t0_clear), .t1_clear(t1_clear));
    irq_cpu_model i_irq_cpu_model (.clk(clk), .rst(rst), .ack_en(ack_en), .ack_wait(ack_wait),
        .ret_cmd(ret_cmd), .irq_req(irq_req), .irq_ack(irq_ack), .irq_return(irq_return));
    // timer peripherals drop their overflow flag on the clear pulse
    always @(posedge clk) begin
        if (t0_clear) src.t0_ovf <= 1'b0;
        if (t1_clear) src.t1_ovf <= 1'b0;
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk);
        sfr <= '0;
    endtask : wr
    // read data is registered, so it is looked at one edge after the address
    task automatic rd8(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        sfr <= '0;
        #1 v = sfr_rdata;
    endtask : rd8
    task automatic take(input logic [7:0] v);
        int n;
        n = 0;
        #1;
        while (irq_ack !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1 n++;
        end
        check("ack_seen", 8'(n < 60), 8'h01);
        @(posedge clk);
        #1 check("irq_vector", irq_vector, v);
    endtask : take
    task automatic quiet(input string n);
        repeat (3) @(posedge clk);
        #1 check(n, 8'(irq_req), 8'h00);
    endtask : quiet
    // end of service also lets every source go idle
    task automatic ret();
        @(posedge clk);
        src <= IDLE;
        ret_cmd <= 1'b1;
        @(posedge clk);
        ret_cmd <= 1'b0;
    endtask : ret
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    // a hang counts as a failure
    initial begin
        #100us;
        num_errors++;
        end_sim();
    end
    initial begin
        rst = 1'b1;
        sfr = '0;
        src = IDLE;
        tmr2_present = 1'b1;
        ack_en = 1'b0;
        ack_wait = 4'h0;
        ret_cmd = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd8(rows[i][23:16], d);
            check("readback", d, rows[i][7:0]);
        end
        // reset in mid-run must bring every register back to zero
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd8(rows[i][23:16], d);
            check("reset_value", d, REG_RESET);
        end
        ack_en <= 1'b1;
        // standard sources, gate shut first, core answering ever slower
        for (int i = 0; i < 6; i++) begin
            ack_wait <= 4'(i);
            wr(ADDR_STD_EN, 8'h01 << i);
            src <= IDLE ^ (19'h1 << pos[i]);
            quiet("gate_closed");
            wr(ADDR_STD_EN, 8'h80 | (8'h01 << i));
            take(VEC_BASE + 8'(8 * i));
            repeat (2) @(posedge clk);
            #1 check("tmr_flag_clr", 8'(src.t0_ovf | src.t1_ovf), 8'h00);
            ret();
        end
        tmr2_present <= 1'b0;
        wr(ADDR_STD_EN, 8'ha0);
        src <= IDLE ^ (19'h1 << 16);
        quiet("tmr2_absent");
        rd8(ADDR_STD_EN, d);
        check("tmr2_stored", d, 8'ha0);
        tmr2_present <= 1'b1;
        take(8'h2b);
        ret();
        // power-fail ignores the global gate
        wr(ADDR_STD_EN, 8'h00);
        wr(ADDR_PF_CTRL, 8'h10);
        quiet("pf_disabled");
        wr(ADDR_PF_CTRL, 8'h30);
        take(8'h33);
        wr(ADDR_PF_CTRL, 8'h20);
        ret();
        src <= IDLE ^ (19'h1 << 8);
        @(posedge clk);
        src <= IDLE;
        take(8'h33);
        wr(ADDR_PF_CTRL, 8'h20);
        ret();
        wr(ADDR_STD_EN, 8'h80);
        wr(ADDR_EXT_EN, 8'hff);
        for (int n = 0; n < 8; n++) begin
            src.ext_lines <= 8'h01 << n;
            @(posedge clk);
            src.ext_lines <= 8'h00;
            take(8'h43 + 8'(8 * n));
            wr(ADDR_EXT_FLAGS, 8'h00);
            ret();
        end
        wr(ADDR_EXT_EN, 8'h7f);
        wr(ADDR_EXT_FLAGS, 8'h80);
        quiet("ext_masked");
        wr(ADDR_EXT_EN, 8'hff);
        take(8'h7b);
        wr(ADDR_EXT_FLAGS, 8'h00);
        ret();
        // line 9 arrives before line 2, both low level
        ack_en <= 1'b0;
        wr(ADDR_EXT_FLAGS, 8'h80);
        wr(ADDR_EXT_FLAGS, 8'h81);
        ack_en <= 1'b1;
        take(8'h7b);
        wr(ADDR_EXT_FLAGS, 8'h01);
        ret();
        take(8'h43);
        wr(ADDR_EXT_FLAGS, 8'h00);
        ret();
        // nesting: only a higher level breaks into a low service
        wr(ADDR_STD_PRIO, 8'h42);
        wr(ADDR_STD_EN, 8'h83);
        src <= IDLE ^ (19'h1 << 12);
        take(8'h03);
        wr(ADDR_EXT_FLAGS, 8'h01);
        quiet("equal_no_preempt");
        wr(ADDR_PF_CTRL, 8'h30);
        take(8'h33);
        wr(ADDR_PF_CTRL, 8'h00);
        ret();
        wr(ADDR_EXT_PRIO, 8'h01);
        take(8'h43);
        wr(ADDR_EXT_FLAGS, 8'h00);
        ret();
        ret();
        // edge mode: one falling step is served once although the pin stays low
        src <= IDLE ^ 19'h00400;
        @(posedge clk);
        src <= IDLE ^ 19'h01400;
        take(8'h03);
        @(posedge clk);
        ret_cmd <= 1'b1;
        @(posedge clk);
        ret_cmd <= 1'b0;
        quiet("edge_once");
        ret();
        quiet("all_served");
        end_sim();
    end
endmodule : mcu_interrupt_enable_priority_unit_tb_top
